// [design/pw_prescale.v]
`timescale 1ns/1ps
`include "pw_timer_regs.vh"

module pw_prescale #(
    parameter PRE_W = 10
) (
    input wire clk_i,
    input wire rst_i,
    input wire [2:0] clock_select_i,
    output reg timer_tick_o
);

    reg [PRE_W-1:0] pre_cnt;
    reg [PRE_W-1:0] mask;
    reg en;

    // tick mask per prescale factor
    always @* begin
        en = 1'b1;
        mask = `PW_MASK_DIV1;
        case (clock_select_i)
            `PW_CS_DIV1: mask = `PW_MASK_DIV1;
            `PW_CS_DIV8: mask = `PW_MASK_DIV8;
            `PW_CS_DIV64: mask = `PW_MASK_DIV64;
            `PW_CS_DIV256: mask = `PW_MASK_DIV256;
            `PW_CS_DIV1024: mask = `PW_MASK_DIV1024;
            default: en = 1'b0;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            pre_cnt <= {PRE_W{1'b0}};
            timer_tick_o <= 1'b0;
        end else begin
            pre_cnt <= pre_cnt + {{(PRE_W-1){1'b0}}, 1'b1};
            timer_tick_o <= en && ((pre_cnt & mask) == mask);
        end
    end

endmodule

// [design/pw_timer.v]
// Behaviour
// - fast mode: overflow flag at maximum
// - fast mode: two non-inverted, three inverted
// - fast: match changes output, wrap restores
// - fast period is 256 ticks
// - fast, compare bottom: one-tick spike
// - fast, compare maximum: constant output level
// - fast mode one toggles on match
// - fast mode compare value double buffered
// - waveform mode one is dual-slope
// - dual-slope: clear up, set down; invertible
// - dual-slope holds maximum one tick, reverses
// - dual-slope resolution fixed eight bits
// - dual-slope overflow flag at bottom
// - dual-slope period is 510 ticks
// - dual-slope extremes give constant levels
// - level at maximum equals up-match result unless compare is maximum
// - missed up-match change still applied
// - counter advances only on timer tick
// - waveform mode three is single-slope
// - reset clears compare output state
`timescale 1ns/1ps
`include "pw_timer_regs.vh"

module pw_timer #(
    parameter PRE_W = 10
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg pwm_output_pin_o,
    output reg pwm_output_en_o,
    output reg overflow_flag_o,
    output reg compare_match_flag_o
);

    // address decode on word offset
    function hit;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            hit = (adr[7:2] == ofs[7:2]);
        end
    endfunction

    // non-pwm compare action
    function nonpwm_level;
        input [1:0] mode;
        input cur;
        begin
            case (mode)
                `PW_COM_TOGGLE: nonpwm_level = ~cur;
                `PW_COM_CLEAR: nonpwm_level = 1'b0;
                `PW_COM_SET: nonpwm_level = 1'b1;
                default: nonpwm_level = cur;
            endcase
        end
    endfunction

    reg [1:0] waveform_mode;
    reg [1:0] compare_output_mode;
    reg [2:0] clock_select;
    reg [7:0] counter_value;
    reg [7:0] compare_value;
    reg [7:0] compare_active;
    reg count_up;
    reg match_block;
    reg compare_output;

    reg [7:0] next_counter_value;
    reg [7:0] next_compare_active;
    reg next_count_up;
    reg next_compare_output;
    reg set_ovf;
    reg set_cmf;
    reg match;
    reg [31:0] next_rdata;

    wire timer_tick;
    wire req;
    wire wr;
    wire wr_lane0;
    // decoded strobes and counter extremes
    wire ctrl_wr;
    wire count_wr;
    wire cmp_wr;
    wire status_wr;
    wire at_max;
    wire at_bottom;

    assign req = wb_cyc_i && wb_stb_i;
    assign wr = req && wb_we_i && wb_ack_o;
    assign wr_lane0 = wr && wb_sel_i[0];

    // per-register write strobes
    assign ctrl_wr = wr_lane0 && hit(wb_adr_i, `PW_CTRL_OFS);
    assign count_wr = wr_lane0 && hit(wb_adr_i, `PW_COUNT_OFS);
    assign cmp_wr = wr_lane0 && hit(wb_adr_i, `PW_CMP_OFS);
    assign status_wr = wr_lane0 && hit(wb_adr_i, `PW_STATUS_OFS);

    // counter extremes
    assign at_max = (counter_value == `PW_MAX);
    assign at_bottom = (counter_value == `PW_BOTTOM);

    pw_prescale #(
        .PRE_W(PRE_W)
    ) u_pre (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clock_select_i(clock_select),
        .timer_tick_o(timer_tick)
    );

    // counter, compare buffer and waveform
    always @* begin
        next_counter_value = counter_value;
        next_compare_active = compare_active;
        next_count_up = count_up;
        next_compare_output = compare_output;
        set_ovf = 1'b0;
        set_cmf = 1'b0;
        match = (counter_value == compare_active) && !match_block;
        // compare value follows at once outside pwm modes
        if (waveform_mode == `PW_WGM_NORMAL || waveform_mode == `PW_WGM_CTC) begin
            next_compare_active = compare_value;
        end
        if (timer_tick) begin
            set_cmf = match;
            case (waveform_mode)
                `PW_WGM_PC: begin
                    if (count_up) begin
                        if (at_max) begin
                            // reverse after one tick at maximum
                            // one tick at each end gives 510
                            next_count_up = 1'b0;
                            next_counter_value = `PW_MAX - 8'h01;
                            next_compare_active = compare_value;
                            if (compare_output_mode[1]) begin
                                if (compare_value == `PW_MAX) begin
                                    next_compare_output = ~compare_output_mode[0];
                                end else begin
                                    next_compare_output = compare_output_mode[0];
                                end
                            end
                        end else begin
                            next_counter_value = counter_value + 8'h01;
                        end
                    end else begin
                        if (at_bottom) begin
                            next_count_up = 1'b1;
                            next_counter_value = `PW_BOTTOM + 8'h01;
                        end else begin
                            next_counter_value = counter_value - 8'h01;
                            if (counter_value == `PW_BOTTOM + 8'h01) begin
                                set_ovf = 1'b1;
                            end
                        end
                    end
                    if (match && compare_output_mode[1] && !at_max) begin
                        if (count_up || at_bottom) begin
                            next_compare_output = compare_output_mode[0];
                        end else begin
                            next_compare_output = ~compare_output_mode[0];
                        end
                    end
                end
                `PW_WGM_FAST: begin
                    if (counter_value == `PW_MAX) begin
                        next_counter_value = `PW_BOTTOM;
                        set_ovf = 1'b1;
                        next_compare_active = compare_value;
                    end else begin
                        next_counter_value = counter_value + 8'h01;
                    end
                    if (match && compare_output_mode[1]) begin
                        next_compare_output = compare_output_mode[0];
                    end
                    if (at_max && compare_output_mode[1]) begin
                        next_compare_output = ~compare_output_mode[0];
                    end
                    if (match && compare_output_mode == `PW_COM_TOGGLE) begin
                        next_compare_output = ~compare_output;
                    end
                end
                `PW_WGM_CTC: begin
                    if (match) begin
                        next_counter_value = `PW_BOTTOM;
                    end else begin
                        next_counter_value = counter_value + 8'h01;
                    end
                    if (counter_value == `PW_MAX) begin
                        set_ovf = 1'b1;
                    end
                    if (match) begin
                        next_compare_output = nonpwm_level(compare_output_mode,
                                                           compare_output);
                    end
                end
                default: begin
                    next_counter_value = counter_value + 8'h01;
                    if (counter_value == `PW_MAX) begin
                        set_ovf = 1'b1;
                    end
                    if (match) begin
                        next_compare_output = nonpwm_level(compare_output_mode,
                                                           compare_output);
                    end
                end
            endcase
        end
    end

    // read data mux
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit(wb_adr_i, `PW_CTRL_OFS)) begin
            next_rdata[`PW_CTRL_WGM_MSB:`PW_CTRL_WGM_LSB] = waveform_mode;
            next_rdata[`PW_CTRL_COM_MSB:`PW_CTRL_COM_LSB] = compare_output_mode;
            next_rdata[`PW_CTRL_CS_MSB:`PW_CTRL_CS_LSB] = clock_select;
        end else if (hit(wb_adr_i, `PW_COUNT_OFS)) begin
            next_rdata[7:0] = counter_value;
        end else if (hit(wb_adr_i, `PW_CMP_OFS)) begin
            next_rdata[7:0] = compare_value;
        end else if (hit(wb_adr_i, `PW_STATUS_OFS)) begin
            next_rdata[`PW_ST_OVF] = overflow_flag_o;
            next_rdata[`PW_ST_CMF] = compare_match_flag_o;
            next_rdata[`PW_ST_OUT] = compare_output;
            next_rdata[`PW_ST_UP] = count_up;
        end else if (hit(wb_adr_i, `PW_ACTIVE_OFS)) begin
            next_rdata[7:0] = compare_active;
        end
    end

    // bus slave: ack one cycle after request, write at ack edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            if (req && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // control and compare registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            waveform_mode <= `PW_WGM_NORMAL;
            compare_output_mode <= `PW_COM_OFF;
            clock_select <= `PW_CS_STOP;
            compare_value <= `PW_CMP_RST;
        end else begin
            if (ctrl_wr) begin
                waveform_mode <= wb_dat_i[`PW_CTRL_WGM_MSB:`PW_CTRL_WGM_LSB];
                compare_output_mode <= wb_dat_i[`PW_CTRL_COM_MSB:`PW_CTRL_COM_LSB];
                clock_select <= wb_dat_i[`PW_CTRL_CS_MSB:`PW_CTRL_CS_LSB];
            end
            if (cmp_wr) begin
                compare_value <= wb_dat_i[7:0];
            end
        end
    end

    // counter state and waveform state
    always @(posedge clk_i) begin
        if (rst_i) begin
            counter_value <= `PW_COUNT_RST;
            compare_active <= `PW_CMP_RST;
            count_up <= 1'b1;
            match_block <= 1'b0;
            compare_output <= 1'b0;
            pwm_output_pin_o <= 1'b0;
            pwm_output_en_o <= 1'b0;
        end else begin
            compare_active <= next_compare_active;
            count_up <= next_count_up;
            compare_output <= next_compare_output;
            pwm_output_pin_o <= next_compare_output;
            pwm_output_en_o <= (compare_output_mode != `PW_COM_OFF);
            if (count_wr) begin
                // counter write blocks the match on the next tick
                counter_value <= wb_dat_i[7:0];
                match_block <= 1'b1;
            end else begin
                counter_value <= next_counter_value;
                if (timer_tick) begin
                    match_block <= 1'b0;
                end
            end
        end
    end

    // sticky flags, write one to clear, set wins
    always @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag_o <= 1'b0;
            compare_match_flag_o <= 1'b0;
        end else begin
            if (set_ovf) begin
                overflow_flag_o <= 1'b1;
            end else if (status_wr && wb_dat_i[`PW_ST_OVF]) begin
                overflow_flag_o <= 1'b0;
            end
            if (set_cmf) begin
                compare_match_flag_o <= 1'b1;
            end else if (status_wr && wb_dat_i[`PW_ST_CMF]) begin
                compare_match_flag_o <= 1'b0;
            end
        end
    end

endmodule

// [design/pw_timer_regs.vh]
`ifndef PW_TIMER_REGS_VH
`define PW_TIMER_REGS_VH

// register byte offsets
`define PW_CTRL_OFS 8'h00
`define PW_COUNT_OFS 8'h04
`define PW_CMP_OFS 8'h08
`define PW_STATUS_OFS 8'h0C
`define PW_ACTIVE_OFS 8'h10

// control field positions
`define PW_CTRL_WGM_LSB 0
`define PW_CTRL_WGM_MSB 1
`define PW_CTRL_COM_LSB 2
`define PW_CTRL_COM_MSB 3
`define PW_CTRL_CS_LSB 4
`define PW_CTRL_CS_MSB 6

// status field positions
`define PW_ST_OVF 0
`define PW_ST_CMF 1
`define PW_ST_OUT 2
`define PW_ST_UP 3

// reset values
`define PW_CTRL_RST 7'h00
`define PW_COUNT_RST 8'h00
`define PW_CMP_RST 8'h00

// waveform modes
`define PW_WGM_NORMAL 2'h0
`define PW_WGM_PC 2'h1
`define PW_WGM_CTC 2'h2
`define PW_WGM_FAST 2'h3

// compare output modes
`define PW_COM_OFF 2'h0
`define PW_COM_TOGGLE 2'h1
`define PW_COM_CLEAR 2'h2
`define PW_COM_SET 2'h3

// counter extremes
`define PW_BOTTOM 8'h00
`define PW_MAX 8'hFF

// prescaler selects and tick masks for /1, /8, /64, /256, /1024
`define PW_CS_STOP 3'h0
`define PW_CS_DIV1 3'h1
`define PW_CS_DIV8 3'h2
`define PW_CS_DIV64 3'h3
`define PW_CS_DIV256 3'h4
`define PW_CS_DIV1024 3'h5
`define PW_MASK_DIV1 10'h000
`define PW_MASK_DIV8 10'h007
`define PW_MASK_DIV64 10'h03F
`define PW_MASK_DIV256 10'h0FF
`define PW_MASK_DIV1024 10'h3FF

`endif

// [test/pwt_load.sv]
`timescale 1ns/1ps
module pwt_load (
    input wire clk_i,
    input wire pin_i,
    input wire en_i,
    input wire clr_i,
    output logic [15:0] high_cnt_o,
    output logic [15:0] rise_cnt_o
);
    logic line;
    logic prev;
    // pull-down holds the line low while the pin is not driven
    assign line = en_i ? pin_i : 1'b0;
    always @(posedge clk_i) begin
        prev <= line;
        if (clr_i) begin
            high_cnt_o <= 16'h0000;
            rise_cnt_o <= 16'h0000;
        end else begin
            high_cnt_o <= high_cnt_o + {15'h0000, line};
            rise_cnt_o <= rise_cnt_o + {15'h0000, line & ~prev};
        end
    end
endmodule

// [test/pwt_sva.sv]
`timescale 1ns/1ps
module pwt_sva (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire pwm_output_pin_o,
    input wire pwm_output_en_o,
    input wire overflow_flag_o,
    input wire compare_match_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_RST_OUT: assert property (disable iff (1'b0) rst_i |=> !pwm_output_pin_o
        && !overflow_flag_o && !compare_match_flag_o && !wb_ack_o)
        else $error("outputs not cleared by reset");
    AST_ACK_RESP: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    AST_DAT_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_OVF_HOLD: assert property (overflow_flag_o && !(wb_ack_o && wb_we_i) |=> overflow_flag_o)
        else $error("overflow flag lost");
    AST_CMF_HOLD: assert property (compare_match_flag_o && !(wb_ack_o && wb_we_i)
        |=> compare_match_flag_o)
        else $error("compare flag lost");
    AST_OVF_CLR: assert property ($fell(overflow_flag_o) |-> $past(wb_ack_o && wb_we_i)
        || $past(rst_i))
        else $error("overflow flag fell without write");
endmodule

bind pw_timer pwt_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pwm_output_pin_o(pwm_output_pin_o), .pwm_output_en_o(pwm_output_en_o),
    .overflow_flag_o(overflow_flag_o), .compare_match_flag_o(compare_match_flag_o));

// [test/testbench.sv]
`timescale 1ns/1ps
`include "pw_timer_regs.vh"
module testbench;
    typedef struct packed {
        logic [1:0] wgm;
        logic [1:0] com;
        logic [7:0] cmp;
        logic [9:0] win;
        logic [9:0] high;
        logic [1:0] rises;
    } pwt_row_t;
    // waveform rows: mode, polarity, compare, window, high ticks, rising edges
    pwt_row_t rows [0:10] = '{
        '{2'h3, 2'h2, 8'h3F, 10'h100, 10'h040, 2'h1},
        '{2'h3, 2'h3, 8'h3F, 10'h100, 10'h0C0, 2'h1},
        '{2'h3, 2'h2, 8'h00, 10'h100, 10'h001, 2'h1},
        '{2'h3, 2'h2, 8'hFF, 10'h100, 10'h100, 2'h0},
        '{2'h3, 2'h3, 8'hFF, 10'h100, 10'h000, 2'h0},
        '{2'h3, 2'h1, 8'h40, 10'h200, 10'h100, 2'h1},
        '{2'h1, 2'h2, 8'h40, 10'h1FE, 10'h080, 2'h1},
        '{2'h1, 2'h3, 8'h40, 10'h1FE, 10'h17E, 2'h1},
        '{2'h1, 2'h2, 8'h00, 10'h1FE, 10'h000, 2'h0},
        '{2'h1, 2'h2, 8'hFF, 10'h1FE, 10'h1FE, 2'h0},
        '{2'h1, 2'h3, 8'h00, 10'h1FE, 10'h1FE, 2'h0}
    };
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [3:0] wsel = 4'hF;
    logic clr = 1'b0;
    logic [31:0] rd;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, pin, pen, ovf, cmf;
    wire [15:0] high_cnt, rise_cnt;
    integer miscompares = 0;
    integer compares = 0;
    integer i;

    always #2.5 clk_i = ~clk_i;

    pw_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pwm_output_pin_o(pin), .pwm_output_en_o(pen),
        .overflow_flag_o(ovf), .compare_match_flag_o(cmf));
    pwt_load u_load (.clk_i(clk_i), .pin_i(pin), .en_i(pen), .clr_i(clr),
        .high_cnt_o(high_cnt), .rise_cnt_o(rise_cnt));

    task end_sim;
        begin
            $display("compares=%0d miscompares=%0d", compares, miscompares);
            if (miscompares == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                $display("Error t=%0t got=%h exp=%h", $time, got, exp);
                miscompares = miscompares + 1;
            end
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            sel <= wsel;
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (wb_ack_o !== 1'b1 && n < 64);
            rd = wb_dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
            sel <= 4'h0;
            if (n >= 64) begin
                miscompares = miscompares + 1;
                end_sim;
            end
        end
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        begin
            wb(1'b0, a, 32'h0);
            chk(rd, exp);
        end
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`PW_CTRL_OFS, 32'h0);
        wb(1'b0, `PW_STATUS_OFS, 32'h0);
        chk(rd & 32'h7, 32'h0);
        for (i = 0; i < 11; i = i + 1) begin
            wb(1'b1, `PW_CMP_OFS, {24'h0, rows[i].cmp});
            wb(1'b1, `PW_CTRL_OFS, {25'h0, `PW_CS_DIV1, rows[i].com, rows[i].wgm});
            repeat (1100) @(posedge clk_i);
            wb(1'b1, `PW_STATUS_OFS, 32'h3);
            clr <= 1'b1;
            @(posedge clk_i);
            clr <= 1'b0;
            repeat (rows[i].win) @(posedge clk_i);
            #1;
            chk(32'(high_cnt), 32'(rows[i].high));
            chk(32'(rise_cnt), 32'(rows[i].rises));
            chk(32'(pen), 32'h1);
            chk(32'(cmf), 32'h1);
            chk(32'(ovf), 32'h1);
            wb(1'b0, `PW_STATUS_OFS, 32'h0);
            chk(rd & 32'h1, 32'h1);
        end
        // compare value buffered while stopped
        wb(1'b1, `PW_CTRL_OFS, {25'h0, `PW_CS_STOP, `PW_COM_CLEAR, `PW_WGM_FAST});
        wb(1'b1, `PW_COUNT_OFS, 32'h50);
        wb(1'b1, `PW_CMP_OFS, 32'h10);
        rdc(`PW_ACTIVE_OFS, 32'h0);
        repeat (50) @(posedge clk_i);
        rdc(`PW_COUNT_OFS, 32'h50);
        wb(1'b1, `PW_CTRL_OFS, {25'h0, `PW_CS_DIV1, `PW_COM_CLEAR, `PW_WGM_FAST});
        repeat (300) @(posedge clk_i);
        rdc(`PW_ACTIVE_OFS, 32'h10);
        wb(1'b1, `PW_CTRL_OFS, {25'h0, `PW_CS_STOP, `PW_COM_CLEAR, `PW_WGM_PC});
        wb(1'b1, `PW_CMP_OFS, 32'h20);
        rdc(`PW_ACTIVE_OFS, 32'h10);
        wb(1'b1, `PW_CTRL_OFS, {25'h0, `PW_CS_DIV1, `PW_COM_CLEAR, `PW_WGM_PC});
        repeat (600) @(posedge clk_i);
        rdc(`PW_ACTIVE_OFS, 32'h20);
        // unmapped and read-only places
        rdc(8'h1C, 32'h0);
        wb(1'b1, 8'h1C, 32'hFF);
        wb(1'b1, `PW_ACTIVE_OFS, 32'h77);
        rdc(`PW_ACTIVE_OFS, 32'h20);
        rdc(`PW_CMP_OFS, 32'h20);
        // write with lane 0 disabled is ignored
        wsel = 4'hE;
        wb(1'b1, `PW_CMP_OFS, 32'h55);
        wsel = 4'hF;
        rdc(`PW_CMP_OFS, 32'h20);
        // reset in mid-run
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(32'(pin), 32'h0);
        chk(32'(pen), 32'h0);
        wb(1'b0, `PW_STATUS_OFS, 32'h0);
        chk(rd & 32'h7, 32'h0);
        rdc(`PW_CTRL_OFS, 32'h0);
        // missed up-count match still acts at maximum
        wb(1'b1, `PW_CTRL_OFS, {25'h0, `PW_CS_DIV1, `PW_COM_SET, `PW_WGM_NORMAL});
        wb(1'b1, `PW_CTRL_OFS, {25'h0, `PW_CS_STOP, `PW_COM_SET, `PW_WGM_NORMAL});
        wb(1'b1, `PW_COUNT_OFS, 32'h80);
        wb(1'b1, `PW_CMP_OFS, 32'h10);
        wb(1'b1, `PW_CTRL_OFS, {25'h0, `PW_CS_DIV1, `PW_COM_CLEAR, `PW_WGM_PC});
        repeat (50) @(posedge clk_i);
        #1;
        chk(32'(pin), 32'h1);
        repeat (150) @(posedge clk_i);
        #1;
        chk(32'(pin), 32'h0);
        end_sim;
    end
endmodule
